// ==== include/csc_defs.svh ====
// Register map, field positions and factory values of the clock synth config bank
// Functional notes
// - Only feedback divider bits seven to one stored
// - Divider B: 2..5 exact, above even
// - Skip bit set bypasses PLL to dividers
// - Prescaler code selects x0.5, x1 or x2
// - Input divider selects ratio 1, 2, 4, 5
// - Enable bit zero floats bank, one drives
// - Style bit one LVDS, zero LVPECL
// - Source codes: crystal, reference, divA, divB
// - Pre-divider A codes give 2, 3, 5, 2
// - Divider A binary 2..63, codes 0,1 invalid
// - Total A equals pre ratio times divider
// - Four factory sets, pins pick active one
// - Frequencies change by pins or serial writes
// - Style and enable writable over serial bus
// - Enable and style act per whole bank
// - Serial slave address 110111 plus select pin
// - Data bytes to ascending registers, MSB first
// - Select pins 00..11 pick sets 0..3
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH
`define CSC_NUM_REGS     8'h18
`define CSC_OFS_FB       5'h00
`define CSC_OFS_NB       5'h04
`define CSC_OFS_PLL      5'h08
`define CSC_OFS_OUT      5'h0C
`define CSC_OFS_MUX      5'h10
`define CSC_OFS_DIVA     5'h14
`define CSC_SKIP_BIT     6
`define CSC_MASK_LOW7    8'h7F
`define CSC_MASK_MUX     8'h0F
`define CSC_MASK_FULL    8'hFF
`define CSC_NB_EVEN_MIN  7'h06
`define CSC_DEV_ADDR_HI  6'h37
`define CSC_FACTORY_DEFAULT \
  192'h8585_8585_0E0E_0E0E_F0F0_F0F0_2121_2121_1010_1010_1919_1919
`endif

// ==== include/csc_pkg.sv ====
// Types shared by the clock synth config bank
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_SRC_XTAL  = 2'b00,
    CSC_SRC_REF   = 2'b01,
    CSC_SRC_DIV_A = 2'b10,
    CSC_SRC_DIV_B = 2'b11
  } csc_src_type;
  typedef enum logic [1:0] {
    CSC_PS_HALF = 2'b00,
    CSC_PS_ONE  = 2'b01,
    CSC_PS_TWO  = 2'b10
  } csc_pscale_type;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_DEV     = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_PTR     = 4'b0011,
    ST_PTR_ACK = 4'b0100,
    ST_WR      = 4'b0101,
    ST_WR_ACK  = 4'b0110,
    ST_RD      = 4'b0111,
    ST_RD_ACK  = 4'b1000
  } csc_state_type;
  typedef struct packed {
    logic [7:0]     feedback_divider;
    logic [6:0]     output_divider_b;
    logic           nb_invalid;
    logic           pll_skip_select;
    csc_pscale_type input_prescaler;
    logic [2:0]     input_clock_divider;
    logic [1:0]     loop_bandwidth;
    logic [3:0]     bank_output_enable;
    logic [3:0]     bank_output_style;
    csc_src_type    bank_a_source;
    csc_src_type    bank_b_source;
    logic [2:0]     pre_divider_a;
    logic [5:0]     output_divider_a;
    logic           na_invalid;
    logic [8:0]     div_a_total;
    logic [1:0]     active_set;
  } csc_cfg_type;
endpackage

// ==== hdl/csc_config_bank.sv ====
// Serial-programmable four-set configuration store with field decoding
`timescale 1ns/1ns
`default_nettype none
`include "csc_defs.svh"
module csc_config_bank #(
  parameter logic [191:0] FACTORY_DEFAULT = `CSC_FACTORY_DEFAULT,
  parameter int unsigned  CH_PER_BANK     = 2
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // Serial configuration pins
  input  wire logic                     scl,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     addr_sel,
  // Set selection pins
  input  wire logic [1:0]               config_set_select,
  // Decoded active configuration
  output csc_pkg::csc_cfg_type          active_cfg,
  output logic [4*CH_PER_BANK-1:0]      chan_enable,
  output logic [4*CH_PER_BANK-1:0]      chan_lvds
);
  import csc_pkg::*;

  logic [1:0]          rst_pipe;
  logic                rst_n;
  logic                scl_q;
  logic                sda_q;
  logic                scl_p;
  logic                sda_p;
  logic                scl_rise;
  logic                scl_fall;
  logic                bus_start;
  logic                bus_stop;
  csc_state_type       state;
  logic [2:0]          bit_cnt;
  logic [7:0]          shift;
  logic [7:0]          reg_ptr;
  logic                read_mode;
  logic [7:0]          byte_in;
  logic                dev_hit;
  logic                ptr_ok;
  logic [4:0]          wr_idx;
  logic [7:0]          wr_data;
  logic                wr_fire;
  logic [7:0]          rd_byte;
  logic [7:0]          cfg_mem [0:23];
  logic [1:0]          sel_q;
  logic [7:0]          fb_raw;
  logic [7:0]          nb_raw;
  logic [7:0]          pll_raw;
  logic [7:0]          out_raw;
  logic [7:0]          mux_raw;
  logic [7:0]          diva_raw;
  logic [6:0]          fb_code;
  logic [6:0]          nb_code;
  csc_cfg_type         next_cfg;

  // Keep reserved bits at zero so reads return zero there
  function automatic logic [7:0] reg_mask(input logic [4:0] idx);
    logic [7:0] m;
    m = `CSC_MASK_FULL;
    if (idx < `CSC_OFS_PLL) begin
      m = `CSC_MASK_LOW7;
    end else if (idx < `CSC_OFS_OUT) begin
      m = `CSC_MASK_LOW7;
    end else if (idx >= `CSC_OFS_MUX && idx < `CSC_OFS_DIVA) begin
      m = `CSC_MASK_MUX;
    end
    return m;
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Pin samples, previous copy for edge and condition detect
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  // Bus events; start and stop need clock high on both samples
  assign scl_rise  = scl_q & ~scl_p;
  assign scl_fall  = ~scl_q & scl_p;
  assign bus_start = scl_q & scl_p & sda_p & ~sda_q;
  assign bus_stop  = scl_q & scl_p & ~sda_p & sda_q;
  assign byte_in   = {shift[6:0], sda_q};
  assign dev_hit   = byte_in[7:1] == {`CSC_DEV_ADDR_HI, addr_sel};
  assign ptr_ok    = reg_ptr < `CSC_NUM_REGS;
  assign wr_idx    = reg_ptr[4:0];
  assign wr_data   = byte_in & reg_mask(wr_idx);
  assign wr_fire   = scl_rise & (state == ST_WR) & (bit_cnt == 3'h7) & ptr_ok;
  // Past the map reads give zero and writes are dropped
  assign rd_byte   = ptr_ok ? cfg_mem[wr_idx] : 8'h00;

  // Transfer sequencer; pointer survives repeated start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      shift     <= 8'h00;
      reg_ptr   <= 8'h00;
      read_mode <= 1'b0;
    end else if (bus_stop) begin
      state <= ST_IDLE;
    end else if (bus_start) begin
      state   <= ST_DEV;
      bit_cnt <= 3'h0;
    end else if (scl_rise) begin
      case (state)
        ST_DEV: begin
          shift   <= byte_in;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            read_mode <= sda_q;
            state     <= dev_hit ? ST_DEV_ACK : ST_IDLE;
          end
        end
        ST_DEV_ACK: begin
          bit_cnt <= 3'h0;
          if (read_mode) begin
            shift   <= rd_byte;
            reg_ptr <= reg_ptr + 8'h01;
            state   <= ST_RD;
          end else begin
            state <= ST_PTR;
          end
        end
        ST_PTR: begin
          shift   <= byte_in;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            reg_ptr <= byte_in;
            state   <= ST_PTR_ACK;
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          bit_cnt <= 3'h0;
          state   <= ST_WR;
        end
        ST_WR: begin
          shift   <= byte_in;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            reg_ptr <= reg_ptr + 8'h01;
            state   <= ST_WR_ACK;
          end
        end
        ST_RD: begin
          shift   <= {shift[6:0], 1'b0};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            state <= ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          bit_cnt <= 3'h0;
          // Master not acknowledging ends the read
          if (sda_q) begin
            state <= ST_IDLE;
          end else begin
            shift   <= rd_byte;
            reg_ptr <= reg_ptr + 8'h01;
            state   <= ST_RD;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Data line changes only while clock is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else if (bus_start || bus_stop) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        ST_DEV_ACK, ST_PTR_ACK, ST_WR_ACK: begin
          sda_oe <= 1'b1;
        end
        ST_RD: begin
          sda_oe <= ~shift[7];
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
  assign sda_out = 1'b0; // Open drain, only pulls low

  // Four sets, factory values at power-up, host overwrites
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 24; i++) begin
        cfg_mem[i] <= FACTORY_DEFAULT[8*i +: 8] & reg_mask(5'(i));
      end
    end else if (wr_fire) begin
      cfg_mem[wr_idx] <= wr_data;
    end
  end

  // Active set follows the select pins at any time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 2'h0;
    end else begin
      sel_q <= config_set_select;
    end
  end

  // Fields of the active set
  assign fb_raw   = cfg_mem[`CSC_OFS_FB + {3'h0, sel_q}];
  assign nb_raw   = cfg_mem[`CSC_OFS_NB + {3'h0, sel_q}];
  assign pll_raw  = cfg_mem[`CSC_OFS_PLL + {3'h0, sel_q}];
  assign out_raw  = cfg_mem[`CSC_OFS_OUT + {3'h0, sel_q}];
  assign mux_raw  = cfg_mem[`CSC_OFS_MUX + {3'h0, sel_q}];
  assign diva_raw = cfg_mem[`CSC_OFS_DIVA + {3'h0, sel_q}];
  assign fb_code  = fb_raw[6:0];
  assign nb_code  = nb_raw[6:0];

  // Decode; invalid codes are flagged, not corrected
  always_comb begin
    next_cfg = '0;
    next_cfg.feedback_divider = {fb_code, 1'b0};
    if (nb_code >= `CSC_NB_EVEN_MIN) begin
      next_cfg.output_divider_b = {nb_code[6:1], 1'b0};
    end else begin
      next_cfg.output_divider_b = nb_code;
    end
    next_cfg.nb_invalid = nb_code[6:1] == 6'h00;
    next_cfg.pll_skip_select = pll_raw[`CSC_SKIP_BIT];
    case (pll_raw[5:4])
      2'h0:    next_cfg.input_prescaler = CSC_PS_HALF;
      2'h1:    next_cfg.input_prescaler = CSC_PS_ONE;
      default: next_cfg.input_prescaler = CSC_PS_TWO;
    endcase
    case (pll_raw[3:2])
      2'h0:    next_cfg.input_clock_divider = 3'h1;
      2'h1:    next_cfg.input_clock_divider = 3'h2;
      2'h2:    next_cfg.input_clock_divider = 3'h4;
      default: next_cfg.input_clock_divider = 3'h5;
    endcase
    next_cfg.loop_bandwidth = pll_raw[1:0];
    next_cfg.bank_output_enable = out_raw[7:4];
    next_cfg.bank_output_style  = out_raw[3:0];
    next_cfg.bank_a_source = csc_src_type'(mux_raw[1:0]);
    next_cfg.bank_b_source = csc_src_type'(mux_raw[3:2]);
    case (diva_raw[7:6])
      2'h1:    next_cfg.pre_divider_a = 3'h3;
      2'h2:    next_cfg.pre_divider_a = 3'h5;
      default: next_cfg.pre_divider_a = 3'h2;
    endcase
    next_cfg.output_divider_a = diva_raw[5:0];
    next_cfg.na_invalid = diva_raw[5:1] == 5'h00;
    next_cfg.div_a_total = 9'(next_cfg.pre_divider_a) * 9'(diva_raw[5:0]);
    next_cfg.active_set = sel_q;
  end

  // Registered decode output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_cfg <= '0;
    end else begin
      active_cfg <= next_cfg;
    end
  end

  // Bank bits fan out to every channel of that bank
  for (genvar j = 0; j < 4*CH_PER_BANK; j++) begin : g_chan
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        chan_enable[j] <= 1'b0;
        chan_lvds[j]   <= 1'b0;
      end else begin
        chan_enable[j] <= next_cfg.bank_output_enable[j / CH_PER_BANK];
        chan_lvds[j]   <= next_cfg.bank_output_style[j / CH_PER_BANK];
      end
    end
  end

  // Checks
  fb_double_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> active_cfg.feedback_divider == {$past(fb_code), 1'b0})
    else $error("feedback divider not twice stored code");
  nb_even_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && nb_code >= 7'h06 |=> !active_cfg.output_divider_b[0] && !active_cfg.nb_invalid)
    else $error("divider B high code not even");
  nb_small_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && nb_code < 7'h06 |=> active_cfg.output_divider_b == $past(nb_code))
    else $error("divider B low code not exact");
  skip_route_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && pll_raw[6] |=> active_cfg.pll_skip_select)
    else $error("skip bit not passed");
  in_div_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && pll_raw[3:2] == 2'h3 |=> active_cfg.input_clock_divider == 3'h5)
    else $error("input divider code 3 not ratio 5");
  pre_div_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && diva_raw[7:6] == 2'h2 |=> active_cfg.pre_divider_a == 3'h5)
    else $error("pre-divider code 2 not ratio 5");
  total_div_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && diva_raw[7:6] == 2'h2 |=>
      active_cfg.div_a_total == 9'h005 * 9'(active_cfg.output_divider_a))
    else $error("divider A total wrong");
  src_sel_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && mux_raw[1:0] == 2'h2 |=> active_cfg.bank_a_source == CSC_SRC_DIV_A)
    else $error("bank A source decode wrong");
  set_follow_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    config_set_select == 2'h3 |-> ##2 active_cfg.active_set == 2'h3)
    else $error("active set not following pins");
  write_store_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wr_fire |=> cfg_mem[$past(wr_idx)] == $past(wr_data) && reg_ptr == $past(reg_ptr) + 8'h01)
    else $error("write not stored or pointer not advanced");
  addr_ack_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    state == ST_DEV_ACK && scl_fall |=> sda_oe)
    else $error("address not acknowledged");
  bank_group_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n && !out_raw[4] |=>
      chan_enable[CH_PER_BANK-1:0] == '0 && !active_cfg.bank_output_enable[0])
    else $error("bank A enable not applied to whole bank");
endmodule
`default_nettype wire

// ==== verif/csc_i2c_host.sv ====
// Serial bus host model that programs the configuration bank
`timescale 1ns/1ns
`default_nettype none
module csc_i2c_host (
  // Clock
  input  wire logic sys_clk,
  // Bus pins, data is open drain
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  logic [7:0] data [0:31];
  logic       acks_ok;

  // Bus idles released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    acks_ok = 1'b1;
  end

  // Five cycles a phase, well above the three-cycle minimum
  task automatic phase();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  // Data moves only while clock is low, so no false start or stop
  task automatic clock_bit(input logic b, output logic s);
    sda_drv = b;
    phase();
    scl = 1'b1;
    phase();
    s = sda_line;
    scl = 1'b0;
    phase();
  endtask

  // Also serves as repeated start
  task automatic start_cond();
    sda_drv = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sda_drv = 1'b0;
    phase();
    scl = 1'b0;
    phase();
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sda_drv = 1'b1;
    phase();
  endtask

  // Most significant bit first, then the acknowledge slot
  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    if (s) acks_ok = 1'b0;
  endtask

  // Last byte is refused so the device lets go of the line
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(last, s);
  endtask

  task automatic write_block(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    acks_ok = 1'b1;
    start_cond();
    put_byte({dev, 1'b0});
    put_byte(ptr);
    for (int i = 0; i < n; i++) put_byte(data[i]);
    stop_cond();
  endtask

  task automatic read_block(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    acks_ok = 1'b1;
    start_cond();
    put_byte({dev, 1'b0});
    put_byte(ptr);
    start_cond();
    put_byte({dev, 1'b1});
    for (int i = 0; i < n; i++) get_byte(i == n - 1, data[i]);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// ==== verif/test_clock_synth_config_bank.sv ====
// Self-checking bench for the clock synth config bank
`timescale 1ns/1ns
`default_nettype none
`include "csc_defs.svh"
module test_clock_synth_config_bank;
  import csc_pkg::*;
  localparam logic [6:0]  DEV    = 7'h6E;
  localparam logic [27:0] NB_TAB = {7'h7F, 7'h07, 7'h02, 7'h01};
  localparam logic [23:0] NA_TAB = {6'h0A, 6'h3F, 6'h14, 6'h02};
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        addr_sel = 1'b0;
  logic [1:0]  config_set_select = 2'h0;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe;
  csc_cfg_type active_cfg;
  logic [7:0]  chan_enable;
  logic [7:0]  chan_lvds;
  wire         sda_line;
  int          failures = 0;
  int          num_checks = 0;

  // Pulled-up data line, low when either party pulls
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  always #4 sys_clk = ~sys_clk;

  csc_config_bank csc_config_bank_inst (
    .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .config_set_select(config_set_select), .active_cfg(active_cfg),
    .chan_enable(chan_enable), .chan_lvds(chan_lvds)
  );
  csc_i2c_host csc_i2c_host_inst (
    .sys_clk(sys_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line)
  );

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Inputs change just after the edge, outputs read once settled
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic sel_set(input logic [1:0] s);
    tick(1);
    config_set_select = s;
    tick(3);
  endtask

  task automatic put_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] v);
    csc_i2c_host_inst.data[0] = v;
    csc_i2c_host_inst.write_block(dev, ptr, 1);
    check({63'h0, csc_i2c_host_inst.acks_ok}, 64'h1);
  endtask

  // Factory set 0 decode, then all 24 bytes read in one burst
  task automatic check_factory();
    csc_cfg_type exp;
    exp = '0;
    exp.feedback_divider = 8'h32;
    exp.output_divider_b = 7'h10;
    exp.input_prescaler = CSC_PS_TWO;
    exp.input_clock_divider = 3'h1;
    exp.loop_bandwidth = 2'h1;
    exp.bank_output_enable = 4'hF;
    exp.bank_a_source = CSC_SRC_DIV_A;
    exp.bank_b_source = CSC_SRC_DIV_B;
    exp.pre_divider_a = 3'h5;
    exp.output_divider_a = 6'h05;
    exp.div_a_total = 9'h019;
    check({7'h00, active_cfg}, {7'h00, exp});
    check({56'h0, chan_enable}, 64'hFF);
    check({56'h0, chan_lvds}, 64'h00);
    csc_i2c_host_inst.read_block(DEV, 8'h00, 24);
    for (int i = 0; i < 24; i++)
      check({56'h0, csc_i2c_host_inst.data[i]}, {56'h0, 8'(`CSC_FACTORY_DEFAULT >> (i * 8))});
  endtask

  // Rewrite set 1 while active, every code of each two-bit field once
  task automatic check_decode();
    csc_cfg_type exp;
    logic [6:0] fb;
    logic [6:0] nb;
    logic [5:0] na;
    logic [1:0] k;
    sel_set(2'h1);
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      fb = 7'h08 + 7'(i * 39);
      nb = NB_TAB[i*7 +: 7];
      na = NA_TAB[i*6 +: 6];
      put_reg(DEV, 8'h01, {1'b0, fb});
      put_reg(DEV, 8'h05, {1'b0, nb});
      put_reg(DEV, 8'h09, {1'b0, k[0], k, k, k});
      put_reg(DEV, 8'h0D, {4'h1 << k, ~(4'h1 << k)});
      put_reg(DEV, 8'h11, {4'h0, k, ~k});
      put_reg(DEV, 8'h15, {k, na});
      exp = '0;
      exp.feedback_divider = {fb, 1'b0};
      exp.output_divider_b = (nb < 7'h06) ? nb : {nb[6:1], 1'b0};
      exp.nb_invalid = (nb < 7'h02);
      exp.pll_skip_select = k[0];
      exp.input_prescaler = (k == 2'h0) ? CSC_PS_HALF : (k == 2'h1) ? CSC_PS_ONE : CSC_PS_TWO;
      exp.input_clock_divider = (k == 2'h3) ? 3'h5 : 3'h1 << k;
      exp.loop_bandwidth = k;
      exp.bank_output_enable = 4'h1 << k;
      exp.bank_output_style = ~(4'h1 << k);
      exp.bank_a_source = csc_src_type'(~k);
      exp.bank_b_source = csc_src_type'(k);
      exp.pre_divider_a = (k == 2'h1) ? 3'h3 : (k == 2'h2) ? 3'h5 : 3'h2;
      exp.output_divider_a = na;
      exp.div_a_total = 9'(exp.pre_divider_a) * 9'(na);
      exp.active_set = 2'h1;
      tick(3);
      check({7'h00, active_cfg}, {7'h00, exp});
      check({7'h00, active_cfg}, {7'h00, exp});
      check({56'h0, chan_enable}, {56'h0, 8'h03 << (2 * k)});
      check({56'h0, chan_lvds}, {56'h0, ~(8'h03 << (2 * k))});
    end
  endtask

  // Pins alone pick the set; only set 1 was rewritten
  task automatic check_select();
    for (int s = 0; s < 4; s++) begin
      sel_set(2'(s));
      check({62'h0, active_cfg.active_set}, 64'(s));
      check({56'h0, active_cfg.feedback_divider}, (s == 1) ? 64'hFA : 64'h32);
    end
  endtask

  // Foreign address ignored; reserved top bit of a divider reads zero
  task automatic check_address();
    csc_i2c_host_inst.data[0] = 8'h00;
    csc_i2c_host_inst.write_block(7'h6F, 8'h00, 1);
    check({63'h0, csc_i2c_host_inst.acks_ok}, 64'h0);
    addr_sel = 1'b1;
    put_reg(7'h6F, 8'h08, 8'h21);
    // Divider 96 keeps the set's bandwidth code 01 legal
    put_reg(7'h6F, 8'h00, 8'hB0);
    csc_i2c_host_inst.read_block(7'h6F, 8'h00, 1);
    check({56'h0, csc_i2c_host_inst.data[0]}, 64'h30);
    addr_sel = 1'b0;
  endtask

  // Main sequence
  initial begin
    tick(20);
    resetn = 1'b1;
    tick(4);
    check_factory();
    check_decode();
    check_select();
    check_address();
    close_out();
  end

  // Watchdog against a hung transfer
  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
